/* logic/peak_pkg.sv */
package peak_pkg;

	// ----------------------------------------------------------------
	// Register map (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [7:0] ADDR_CTRL     = 8'h00;
	localparam logic [7:0] ADDR_SELECT   = 8'h04;
	localparam logic [7:0] ADDR_STATUS   = 8'h08;
	localparam logic [7:0] ADDR_INT_HI   = 8'h0C;
	localparam logic [7:0] ADDR_INT_LO   = 8'h10;
	localparam logic [7:0] ADDR_REAL_HI  = 8'h14;
	localparam logic [7:0] ADDR_REAL_LO  = 8'h18;
	localparam logic [7:0] ADDR_IRQ_STAT = 8'h1C;
	localparam logic [7:0] ADDR_IRQ_CLR  = 8'h20;
	localparam logic [7:0] ADDR_IRQ_EN   = 8'h24;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int CTRL_ENABLE_BIT = 0;
	localparam int CTRL_FORMAT_BIT = 1;
	localparam int SEL_CHAN_LSB    = 0;
	localparam int SEL_POS_LSB     = 8;
	localparam int SEL_GROUP_LSB   = 16;
	localparam int STAT_BUSY_BIT   = 0;
	localparam int STAT_FAULT_BIT  = 1;
	localparam int STAT_TRACK_BIT  = 2;
	localparam int STAT_CODE_LSB   = 8;
	localparam int IRQ_FAULT_BIT   = 0;
	localparam int IRQ_HIGH_BIT    = 1;
	localparam int IRQ_LOW_BIT     = 2;
	localparam int IRQ_WIDTH       = 3;

	// ----------------------------------------------------------------
	// Selection limits and reset values
	// ----------------------------------------------------------------
	localparam logic [7:0] GROUP_HOST     = 8'h00;
	localparam logic [7:0] POSITION_MAX   = 8'h1F;
	localparam logic [7:0] CHANNEL_FIRST  = 8'h01;
	localparam logic [7:0] CHANNEL_SECOND = 8'h02;
	localparam logic [31:0] SELECT_RESET  = 32'h0000_0001;
	localparam logic [31:0] ZERO_WORD     = 32'h0000_0000;
	localparam logic [15:0] ZERO_HALF     = 16'h0000;

	// ----------------------------------------------------------------
	// Fault codes
	// ----------------------------------------------------------------
	typedef enum logic [3:0] {
		fault_none          = 4'h0,
		fault_bad_group     = 4'h1,
		fault_bad_position  = 4'h2,
		fault_bad_channel   = 4'h3,
		fault_no_sample     = 4'h4
	} fault_code_t;

	// Formats
	localparam logic FORMAT_INT  = 1'b0;
	localparam logic FORMAT_REAL = 1'b1;

endpackage

/* logic/peak_tracker.sv */
`timescale 1ns/1ps
`default_nettype none

module peak_tracker (
	input  wire logic        clk,          // System clock, 10 MHz
	input  wire logic        rstn,         // Synchronous reset, active low
	input  wire logic [7:0]  paddr,        // APB address
	input  wire logic        psel,         // APB select
	input  wire logic        penable,      // APB enable
	input  wire logic        pwrite,       // APB direction
	input  wire logic [31:0] pwdata,       // APB write data
	output logic      [31:0] prdata,       // APB read data
	output logic             pready,       // APB ready
	output logic             pslverr,      // APB error on unmapped address
	input  wire logic [15:0] ch1_sample,   // Latest reading, first channel
	input  wire logic [15:0] ch2_sample,   // Latest reading, second channel
	input  wire logic [31:0] ch1_real,     // Latest reading as real, first channel
	input  wire logic [31:0] ch2_real,     // Latest reading as real, second channel
	input  wire logic        sample_valid, // One-cycle strobe: new readings present
	output logic             irq           // Level interrupt
);

	// ----------------------------------------------------------------
	// Software state
	// ----------------------------------------------------------------
	// Written over the bus
	logic                     peak_track_enable;
	logic                     format_real;
	logic [7:0]               channel_select;
	logic [7:0]               module_position;
	logic [7:0]               group_select;

	// Execution flags, moved only by the enable edges; enable_prev copies the enable bit every cycle
	logic                     busy_flag;
	logic                     fault_flag;
	peak_pkg::fault_code_t    fault_code;
	logic                     tracking;
	logic                     enable_prev;

	// Extremes; only the pair of the format last seeded or tracked is ever nonzero
	logic [15:0]              int_highest;
	logic [15:0]              int_lowest;
	logic [31:0]              real_highest;
	logic [31:0]              real_lowest;

	// Interrupt status and mask
	logic [peak_pkg::IRQ_WIDTH-1:0] irq_status;
	logic [peak_pkg::IRQ_WIDTH-1:0] irq_enable;

	// Decode, detection and next-value nets
	logic                     apb_access;
	logic                     apb_wr;
	logic                     rise;
	logic                     fall;
	peak_pkg::fault_code_t    next_fault;
	logic [15:0]              cur_int;
	logic [31:0]              cur_real;
	logic                     new_high;
	logic                     new_low;
	logic [peak_pkg::IRQ_WIDTH-1:0] irq_events;
	logic [peak_pkg::IRQ_WIDTH-1:0] irq_clear;
	logic                     start_ok;
	logic                     start_fault;
	logic [peak_pkg::IRQ_WIDTH-1:0] next_irq_status;

	// ----------------------------------------------------------------
	// Helper functions
	// ----------------------------------------------------------------
	// Channel decode shared by both reading muxes; an invalid channel never starts tracking
	function automatic logic is_second(input logic [7:0] sel);
		return sel == peak_pkg::CHANNEL_SECOND;
	endfunction

	// Widen a signed reading to a bus word so negative extremes read back negative
	function automatic logic [31:0] sign_word(input logic [15:0] v);
		return {{16{v[15]}}, v};
	endfunction

	// Signed compare of two IEEE singles; NaNs are not expected from the channel
	function automatic logic real_greater(input logic [31:0] a, input logic [31:0] b);
		logic r;
		r = 1'b0;
		if (a[31] != b[31]) begin
			// Opposite signs: a wins when b is negative, unless both are zeros
			r = b[31] && ((a[30:0] | b[30:0]) != 31'd0);
		end else if (!a[31]) begin
			r = a[30:0] > b[30:0];
		end else begin
			// Both negative: the smaller magnitude is the greater value
			r = a[30:0] < b[30:0];
		end
		return r;
	endfunction

	// ----------------------------------------------------------------
	// Strobes and decode
	// ----------------------------------------------------------------
	// Zero wait states: every access completes in its first access cycle
	assign apb_access = psel && penable;
	assign apb_wr     = apb_access && pwrite;
	// Enable edges; both registers are low out of reset, so no false edge follows it
	assign rise       = peak_track_enable && !enable_prev;
	assign fall       = !peak_track_enable && enable_prev;

	// Outcome of the selection check, meaningful only in the cycle of a rising enable
	assign start_ok    = rise && (next_fault == peak_pkg::fault_none);
	assign start_fault = rise && (next_fault != peak_pkg::fault_none);

	// Selected channel's latest readings
	assign cur_int  = is_second(channel_select) ? ch2_sample : ch1_sample;
	assign cur_real = is_second(channel_select) ? ch2_real : ch1_real;

	// ----------------------------------------------------------------
	// Selection check at start-up
	// ----------------------------------------------------------------
	// Group first, then position, then channel; only one code is reported
	always_comb begin
		if (group_select != peak_pkg::GROUP_HOST) begin
			next_fault = peak_pkg::fault_bad_group;
		end else if (module_position > peak_pkg::POSITION_MAX) begin
			next_fault = peak_pkg::fault_bad_position;
		end else if (channel_select != peak_pkg::CHANNEL_FIRST &&
			channel_select != peak_pkg::CHANNEL_SECOND) begin
			next_fault = peak_pkg::fault_bad_channel;
		end else begin
			next_fault = peak_pkg::fault_none;
		end
	end

	// ----------------------------------------------------------------
	// Extreme detection
	// ----------------------------------------------------------------
	// New extremes only while tracking and a fresh sample arrives
	always_comb begin
		new_high = 1'b0;
		new_low  = 1'b0;
		// A sample in the start cycle itself is covered by the seed
		if (tracking && sample_valid) begin
			if (format_real == peak_pkg::FORMAT_REAL) begin
				new_high = real_greater(cur_real, real_highest);
				new_low  = real_greater(real_lowest, cur_real);
			end else begin
				// Integer readings are two's complement
				new_high = $signed(cur_int) > $signed(int_highest);
				new_low  = $signed(cur_int) < $signed(int_lowest);
			end
		end
	end

	// Event sources: start fault, new highest, new lowest
	assign irq_events = {new_low, new_high, start_fault};
	assign irq_clear  = (apb_wr && paddr == peak_pkg::ADDR_IRQ_CLR) ?
		pwdata[peak_pkg::IRQ_WIDTH-1:0] : '0;

	// ----------------------------------------------------------------
	// Software-written registers
	// ----------------------------------------------------------------
	// Writes land at the access edge, where pready is always high
	always_ff @(posedge clk) begin
		if (!rstn) begin
			peak_track_enable <= 1'b0;
			format_real       <= peak_pkg::FORMAT_INT;
			channel_select    <= peak_pkg::SELECT_RESET[7:0];
			module_position   <= peak_pkg::SELECT_RESET[15:8];
			group_select      <= peak_pkg::SELECT_RESET[23:16];
			irq_enable        <= '0;
		end else if (apb_wr) begin
			// Enable and format share one word, so a start can pick its format in the same write
			if (paddr == peak_pkg::ADDR_CTRL) begin
				peak_track_enable <= pwdata[peak_pkg::CTRL_ENABLE_BIT];
				format_real       <= pwdata[peak_pkg::CTRL_FORMAT_BIT];
			end
			// Selections are checked at the next rising enable only, never while enabled
			if (paddr == peak_pkg::ADDR_SELECT) begin
				channel_select  <= pwdata[peak_pkg::SEL_CHAN_LSB +: 8];
				module_position <= pwdata[peak_pkg::SEL_POS_LSB +: 8];
				group_select    <= pwdata[peak_pkg::SEL_GROUP_LSB +: 8];
			end
			// Reset leaves every interrupt source masked
			if (paddr == peak_pkg::ADDR_IRQ_EN) begin
				irq_enable <= pwdata[peak_pkg::IRQ_WIDTH-1:0];
			end
		end
	end

	// ----------------------------------------------------------------
	// Execution state: busy, fault, tracking
	// ----------------------------------------------------------------
	// Busy rises at every start, fault with it on a bad selection; withdrawal clears them in one edge
	always_ff @(posedge clk) begin
		if (!rstn) begin
			enable_prev <= 1'b0;
			busy_flag   <= 1'b0;
			fault_flag  <= 1'b0;
			fault_code  <= peak_pkg::fault_none;
			tracking    <= 1'b0;
		end else begin
			enable_prev <= peak_track_enable;
			if (rise) begin
				busy_flag <= 1'b1;
				if (next_fault != peak_pkg::fault_none) begin
					// Bad selections leave the extremes as they were
					fault_flag <= 1'b1;
					fault_code <= next_fault;
					tracking   <= 1'b0;
				end else begin
					tracking   <= 1'b1;
				end
			end else if (fall) begin
				// Withdrawal ends the run and any pending fault together
				busy_flag  <= 1'b0;
				fault_flag <= 1'b0;
				fault_code <= peak_pkg::fault_none;
				tracking   <= 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// Extreme tracking; the idle format's pair is zeroed at the seed and while tracking
	// ----------------------------------------------------------------
	// A faulted start never reaches the seed, so old extremes survive it
	always_ff @(posedge clk) begin
		if (!rstn) begin
			int_highest  <= peak_pkg::ZERO_HALF;
			int_lowest   <= peak_pkg::ZERO_HALF;
			real_highest <= peak_pkg::ZERO_WORD;
			real_lowest  <= peak_pkg::ZERO_WORD;
		end else if (start_ok) begin
			// Seed both extremes from the latest reading
			if (format_real == peak_pkg::FORMAT_REAL) begin
				real_highest <= cur_real;
				real_lowest  <= cur_real;
				int_highest  <= peak_pkg::ZERO_HALF;
				int_lowest   <= peak_pkg::ZERO_HALF;
			end else begin
				int_highest  <= cur_int;
				int_lowest   <= cur_int;
				real_highest <= peak_pkg::ZERO_WORD;
				real_lowest  <= peak_pkg::ZERO_WORD;
			end
		end else if (tracking) begin
			// Outside tracking nothing moves, so values hold from one edge after enable drops
			if (format_real == peak_pkg::FORMAT_REAL) begin
				if (new_high) begin
					real_highest <= cur_real;
				end
				if (new_low) begin
					real_lowest <= cur_real;
				end
				int_highest <= peak_pkg::ZERO_HALF;
				int_lowest  <= peak_pkg::ZERO_HALF;
			end else begin
				if (new_high) begin
					int_highest <= cur_int;
				end
				if (new_low) begin
					int_lowest <= cur_int;
				end
				real_highest <= peak_pkg::ZERO_WORD;
				real_lowest  <= peak_pkg::ZERO_WORD;
			end
		end
	end

	// ----------------------------------------------------------------
	// Interrupts: sticky status, set wins over clear
	// ----------------------------------------------------------------
	// Set wins over clear: an event in the clearing cycle stays pending
	assign next_irq_status = (irq_status & ~irq_clear) | irq_events;

	// Irq follows the new status at once; a mask write reaches it one edge later
	always_ff @(posedge clk) begin
		if (!rstn) begin
			irq_status <= '0;
			irq        <= 1'b0;
		end else begin
			irq_status <= next_irq_status;
			irq        <= |(next_irq_status & irq_enable);
		end
	end

	// ----------------------------------------------------------------
	// APB slave answer
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!rstn) begin
			prdata  <= peak_pkg::ZERO_WORD;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			// Ready is registered: asserted in the first access cycle by the setup-cycle decode
			pready  <= psel && !penable;
			// Defaults for every cycle that is not a setup
			pslverr <= 1'b0;
			prdata  <= peak_pkg::ZERO_WORD;
			// Captured in setup: a change during the access cycle shows on the next read
			if (psel && !penable) begin
				unique case (paddr)
					peak_pkg::ADDR_CTRL: begin
						prdata[peak_pkg::CTRL_ENABLE_BIT] <= peak_track_enable;
						prdata[peak_pkg::CTRL_FORMAT_BIT] <= format_real;
					end
					peak_pkg::ADDR_SELECT: begin
						prdata <= {8'h00, group_select, module_position, channel_select};
					end
					peak_pkg::ADDR_STATUS: begin
						prdata[peak_pkg::STAT_BUSY_BIT]  <= busy_flag;
						prdata[peak_pkg::STAT_FAULT_BIT] <= fault_flag;
						prdata[peak_pkg::STAT_TRACK_BIT] <= tracking;
						prdata[peak_pkg::STAT_CODE_LSB +: 4] <= fault_code;
					end
					peak_pkg::ADDR_INT_HI:   prdata <= sign_word(int_highest);
					peak_pkg::ADDR_INT_LO:   prdata <= sign_word(int_lowest);
					peak_pkg::ADDR_REAL_HI:  prdata <= real_highest;
					peak_pkg::ADDR_REAL_LO:  prdata <= real_lowest;
					peak_pkg::ADDR_IRQ_STAT: prdata[peak_pkg::IRQ_WIDTH-1:0] <= irq_status;
					// The clear register is write-only and reads zero
					peak_pkg::ADDR_IRQ_CLR:  prdata <= peak_pkg::ZERO_WORD;
					peak_pkg::ADDR_IRQ_EN:   prdata[peak_pkg::IRQ_WIDTH-1:0] <= irq_enable;
					// Unmapped or misaligned: error answer with zero data
					default:                 pslverr <= 1'b1;
				endcase
			end
		end
	end

endmodule

`default_nettype wire

/* verif/peak_checker.sv */
`timescale 1ns/1ps
`default_nettype none
// ------
// Port checker
// ------
module peak_checker (
	input wire logic        clk,          // Clock
	input wire logic        rstn,         // Reset, active low
	input wire logic [7:0]  paddr,        // APB address
	input wire logic        psel,         // APB select
	input wire logic        penable,      // APB enable
	input wire logic        pwrite,       // APB direction
	input wire logic [31:0] pwdata,       // APB write data
	input wire logic [31:0] prdata,       // APB read data
	input wire logic        pready,       // APB ready
	input wire logic        pslverr,      // APB error
	input wire logic [15:0] ch1_sample,   // Reading, channel 1
	input wire logic [15:0] ch2_sample,   // Reading, channel 2
	input wire logic [31:0] ch1_real,     // Real reading, channel 1
	input wire logic [31:0] ch2_real,     // Real reading, channel 2
	input wire logic        sample_valid, // New readings strobe
	input wire logic        irq           // Interrupt
);
	logic en_q;  // Enable bit as last written
	logic wr_ok; // Write completes at this edge
	logic rd_st; // Status answer on the bus
	assign wr_ok = psel && penable && pready && pwrite;
	assign rd_st = psel && penable && pready && !pwrite && paddr == peak_pkg::ADDR_STATUS;
	// Status answers are registered in setup, so they are judged against enable two edges back
	always_ff @(posedge clk) begin
		if (!rstn) begin
			en_q <= 1'b0;
		end else if (wr_ok && paddr == peak_pkg::ADDR_CTRL) begin
			en_q <= pwdata[peak_pkg::CTRL_ENABLE_BIT];
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);
	reset_quiet_a: assert property (disable iff (1'b0) !rstn |=> !irq && !pready && !pslverr)
		else $error("outputs not quiet after reset");
	ready_timing_a: assert property (psel && !penable |=> pready) else $error("pready late");
	ready_pulse_a: assert property (pready |=> !pready) else $error("pready too long");
	slverr_addr_a: assert property (pslverr |-> pready && (paddr > peak_pkg::ADDR_IRQ_EN || paddr[1:0] != 2'b00))
		else $error("pslverr on mapped address");
	idle_data_a: assert property (!pready |-> prdata == 32'h0000_0000) else $error("prdata not zero");
	busy_enable_a: assert property (rd_st && prdata[0] |-> $past(en_q, 2)) else $error("busy without enable");
	fault_clear_a: assert property (rd_st && prdata[1] |-> $past(en_q, 2)) else $error("fault kept");
	fault_code_a: assert property (rd_st |-> prdata[1] == (prdata[11:8] != 4'h0)) else $error("code mismatch");
	no_track_a: assert property (rd_st && prdata[2] |-> !prdata[1]) else $error("tracking while faulted");
	irq_mask_a: assert property (wr_ok && paddr == peak_pkg::ADDR_IRQ_EN && pwdata[2:0] == 3'b000 |=> ##1 !irq)
		else $error("irq not masked");
endmodule
bind peak_tracker peak_checker u_checker (.clk, .rstn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
	.pready, .pslverr, .ch1_sample, .ch2_sample, .ch1_real, .ch2_real, .sample_valid, .irq);
`default_nettype wire

/* verif/sample_source.sv */
`timescale 1ns/1ps
`default_nettype none
// ------
// Measurement source
// ------
module sample_source (
	input  wire logic        clk,         // Clock
	output logic      [15:0] ch1_sample,  // Reading, channel 1
	output logic      [15:0] ch2_sample,  // Reading, channel 2
	output logic      [31:0] ch1_real,    // Real reading, channel 1
	output logic      [31:0] ch2_real,    // Real reading, channel 2
	output logic             sample_valid // New readings strobe
);
	// Defined levels from time zero so no unknown reading is ever compared
	initial begin
		ch1_sample = 16'h0000;
		ch2_sample = 16'h0000;
		ch1_real = 32'h0000_0000;
		ch2_real = 32'h0000_0000;
		sample_valid = 1'b0;
	end
	// One reading pair per call; strobe held for exactly one cycle
	task automatic put(input logic [15:0] a, input logic [15:0] b);
		@(posedge clk);
		ch1_sample <= a;
		ch2_sample <= b;
		ch1_real <= $shortrealtobits(shortreal'($signed(a)));
		ch2_real <= $shortrealtobits(shortreal'($signed(b)));
		sample_valid <= 1'b1;
		@(posedge clk);
		sample_valid <= 1'b0;
		@(posedge clk);
	endtask
endmodule
`default_nettype wire

/* verif/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic        clk = 1'b0;
	logic        rstn = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] prdata, ch1_real, ch2_real, rdat;
	logic [15:0] ch1_sample, ch2_sample;
	logic        pready, pslverr, irq, sample_valid, rerr;
	int          fail_count = 0;
	int          n_checks = 0;
	// ------
	// Clock, design and source
	// ------
	always #50 clk = ~clk;
	peak_tracker uut (.clk, .rstn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr,
		.ch1_sample, .ch2_sample, .ch1_real, .ch2_real, .sample_valid, .irq);
	sample_source src (.clk, .ch1_sample, .ch2_sample, .ch1_real, .ch2_real, .sample_valid);
	// ------
	// Bus and compare helpers
	// ------
	task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			fail_count++;
			$display("FAIL %s expected %h seen %h", nm, e, g);
		end
	endtask
	// Request stands until pready is seen high at a rising edge; data and error are taken there
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1) @(posedge clk);
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		xfer(1'b1, a, d);
	endtask
	task automatic chk(input logic [7:0] a, input logic [31:0] e);
		xfer(1'b0, a, 32'h0000_0000);
		cmp($sformatf("reg %h", a), e, rdat);
	endtask
	// Rising enable is seen one cycle after the write lands
	task automatic ctl(input logic [31:0] d);
		wr(peak_pkg::ADDR_CTRL, d);
		repeat (2) @(posedge clk);
	endtask
	task automatic irq_is(input logic v);
		@(negedge clk);
		cmp("irq", {31'h0, v}, {31'h0, irq});
		@(posedge clk);
	endtask
	function automatic logic [31:0] fb(input int v);
		return $shortrealtobits(shortreal'(v));
	endfunction
	// ------
	// Scenarios
	// ------
	task automatic t_reset;
		chk(peak_pkg::ADDR_SELECT, peak_pkg::SELECT_RESET);
		chk(peak_pkg::ADDR_STATUS, 32'h0000_0000);
		xfer(1'b0, 8'h28, 32'h0000_0000);
		cmp("slverr", 32'h0000_0001, {31'h0, rerr});
		$display("test reset done");
	endtask
	task automatic t_int;
		src.put(16'd100, 16'd7);
		wr(peak_pkg::ADDR_SELECT, 32'h0000_1F01);
		ctl(32'h0000_0001);
		chk(peak_pkg::ADDR_CTRL, 32'h0000_0001);
		chk(peak_pkg::ADDR_STATUS, 32'h0000_0005);
		chk(peak_pkg::ADDR_INT_HI, 32'd100);
		chk(peak_pkg::ADDR_INT_LO, 32'd100);
		src.put(16'd300, 16'd900);
		src.put(16'hFFCE, 16'hFC7C);
		chk(peak_pkg::ADDR_INT_HI, 32'd300);
		chk(peak_pkg::ADDR_INT_LO, 32'hFFFF_FFCE);
		chk(peak_pkg::ADDR_REAL_HI, 32'h0000_0000);
		ctl(32'h0000_0000);
		src.put(16'd999, 16'd999);
		chk(peak_pkg::ADDR_INT_HI, 32'd300);
		chk(peak_pkg::ADDR_STATUS, 32'h0000_0000);
		$display("test integer tracking done");
	endtask
	task automatic t_real;
		src.put(16'd5, 16'd40);
		wr(peak_pkg::ADDR_SELECT, 32'h0000_0002);
		ctl(32'h0000_0003);
		chk(peak_pkg::ADDR_REAL_HI, fb(40));
		chk(peak_pkg::ADDR_CTRL, 32'h0000_0003);
		chk(peak_pkg::ADDR_INT_HI, 32'h0000_0000);
		src.put(16'd1, 16'hFFF8);
		chk(peak_pkg::ADDR_REAL_LO, fb(-8));
		chk(peak_pkg::ADDR_REAL_HI, fb(40));
		ctl(32'h0000_0002);
		$display("test real tracking done");
	endtask
	task automatic t_fault;
		logic [31:0] sel [5] = '{32'h0001_0001, 32'h0000_2001, 32'h0000_0000, 32'h0000_0003, 32'h0001_2000};
		logic [3:0]  code [5] = '{peak_pkg::fault_bad_group, peak_pkg::fault_bad_position,
			peak_pkg::fault_bad_channel, peak_pkg::fault_bad_channel, peak_pkg::fault_bad_group};
		wr(peak_pkg::ADDR_IRQ_CLR, 32'h0000_0007);
		wr(peak_pkg::ADDR_IRQ_EN, 32'h0000_0001);
		chk(peak_pkg::ADDR_IRQ_EN, 32'h0000_0001);
		chk(peak_pkg::ADDR_IRQ_CLR, 32'h0000_0000);
		for (int i = 0; i < 5; i++) begin
			wr(peak_pkg::ADDR_SELECT, sel[i]);
			ctl(32'h0000_0003);
			chk(peak_pkg::ADDR_STATUS, {20'h0_0000, code[i], 8'h03});
			chk(peak_pkg::ADDR_REAL_HI, fb(40));
			irq_is(1'b1);
			wr(peak_pkg::ADDR_IRQ_CLR, 32'h0000_0001);
			irq_is(1'b0);
			ctl(32'h0000_0002);
			chk(peak_pkg::ADDR_STATUS, 32'h0000_0000);
		end
		wr(peak_pkg::ADDR_IRQ_EN, 32'h0000_0000);
		ctl(32'h0000_0003);
		irq_is(1'b0);
		chk(peak_pkg::ADDR_IRQ_STAT, 32'h0000_0001);
		wr(peak_pkg::ADDR_IRQ_EN, 32'h0000_0001);
		irq_is(1'b1);
		wr(peak_pkg::ADDR_IRQ_CLR, 32'h0000_0001);
		irq_is(1'b0);
		ctl(32'h0000_0002);
		wr(peak_pkg::ADDR_SELECT, 32'h0000_0001);
		ctl(32'h0000_0003);
		chk(peak_pkg::ADDR_STATUS, 32'h0000_0005);
		$display("test faults done");
	endtask
	// ------
	// Run control
	// ------
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	initial begin
		repeat (8) @(posedge clk);
		rstn <= 1'b1;
		@(posedge clk);
		t_reset;
		t_int;
		t_real;
		t_fault;
		wrap_up;
	end
	// Whole run needs well under a thousand cycles
	initial begin
		#200_000;
		fail_count++;
		wrap_up;
	end
endmodule
`default_nettype wire
